// ==== verilog/appc_pkg.sv ====
// Shared constants, types and helpers of the sample post-processing block
package appc_pkg;

	// Sample, coefficient, accumulator and offset-counter widths
	localparam int SMP_W   = 12;
	localparam int COEF_W  = 12;
	localparam int ACC_W   = 29;
	localparam int DC_ACC_W = 41;
	localparam int DC_CNT_W = 30;

	// Register addresses on the serial configuration port
	localparam logic [7:0] ADDR_LAT_DC   = 8'h1a;
	localparam logic [7:0] ADDR_DEC_CTRL = 8'h1b;
	localparam logic [7:0] ADDR_BAND     = 8'h1d;

	// Reset values: whole processing path off
	localparam logic [7:0] RST_LAT_DC   = 8'h00;
	localparam logic [7:0] RST_DEC_CTRL = 8'h00;
	localparam logic [7:0] RST_BAND     = 8'h00;

	// Field positions, latency and time-constant register
	localparam int FAST_BIT = 7;
	localparam int TC_LSB   = 4;
	// Field positions, decimation control register
	localparam int DC_EN_BIT   = 7;
	localparam int COEF_SRC_BIT = 5;
	localparam int FILT_EN_BIT = 4;
	localparam int ODD_TAP_BIT = 3;
	localparam int RATE_LSB    = 0;
	// Field position, band register
	localparam int BAND_LSB = 0;

	// Rate codes
	localparam logic [2:0] RATE_DIV2 = 3'h0;
	localparam logic [2:0] RATE_DIV4 = 3'h1;
	localparam logic [2:0] RATE_NONE = 3'h3;
	localparam logic [2:0] RATE_DIV8 = 3'h4;

	// Latencies in sample clocks and the stages outside the pad
	localparam int LAT_NORMAL  = 14;
	localparam int LAT_FAST    = 10;
	localparam int FRONT_NORM  = 4;
	localparam int FRONT_FAST  = 2;
	localparam int NORM_PAD    = LAT_NORMAL - FRONT_NORM;
	localparam int FAST_PAD    = LAT_FAST - FRONT_FAST;

	// Filter length and sum scaling shift
	localparam int TAPS_EVEN = 24;
	localparam int TAPS_ODD  = 23;
	localparam int SUM_SHIFT = 9;

	// Built-in coefficient magnitude and sign patterns
	localparam logic signed [COEF_W-1:0] BI_MAG = 12'sh010;
	localparam logic [15:0] BP3_NEG = 16'h638c;
	localparam logic [15:0] BP5_NEG = 16'hc926;

	// Serial frame length
	localparam logic [4:0] SER_LAST = 5'h0f;

	// Serial receiver states
	typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_HOLD} appc_ser_t;

	// Averaging exponent from the time-constant code
	function automatic logic [4:0] tc_exponent(input logic [2:0] code);
		unique case (code)
			3'h1:    tc_exponent = 5'd26;
			3'h2:    tc_exponent = 5'd25;
			3'h3:    tc_exponent = 5'd24;
			3'h4:    tc_exponent = 5'd28;
			3'h5:    tc_exponent = 5'd29;
			default: tc_exponent = 5'd27;
		endcase
	endfunction

	// Clip a wide signed value to the sample range
	function automatic logic signed [SMP_W-1:0] sat_smp(
		input logic signed [ACC_W-1:0] v);
		if (v > ACC_W'(2047))
			sat_smp = 12'sh7ff;
		else if (v < -ACC_W'(2048))
			sat_smp = 12'sh800;
		else
			sat_smp = v[SMP_W-1:0];
	endfunction

	// Built-in coefficient for one tap; zero where none is defined
	function automatic logic signed [COEF_W-1:0] builtin_coef(
		input logic [2:0] rate,
		input logic [1:0] band,
		input logic [4:0] idx);
		logic neg;
		logic ok;
		neg = 1'b0;
		ok  = 1'b1;
		if (rate == RATE_DIV2) begin
			neg = band[0] & idx[0];
			ok  = ~band[1];
		end else if (rate == RATE_DIV4) begin
			unique case (band)
				2'h0: neg = 1'b0;
				2'h1: neg = BP3_NEG[idx[3:0]];
				2'h2: neg = BP5_NEG[idx[3:0]];
				2'h3: neg = idx[0];
			endcase
		end else begin
			ok = 1'b0;
		end
		builtin_coef = !ok ? '0 : (neg ? -BI_MAG : BI_MAG);
	endfunction

endpackage

// ==== verilog/appc_cfg_rx.sv ====
// Serial configuration receiver: 8 address bits then 8 data bits
`timescale 1ns/10ps
module appc_cfg_rx (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       cfg_sclk,
	input  wire logic       cfg_sdata,
	input  wire logic       cfg_sen_b,
	output logic            wr_stb,
	output logic [7:0]      wr_addr,
	output logic [7:0]      wr_data
);

	appc_pkg::appc_ser_t state;     // Frame position
	logic              sclk_q;      // Serial clock, one cycle old
	logic [14:0]       shreg;       // Bits taken so far
	logic [4:0]        cnt;         // Bit count in frame
	wire logic         sclk_fall;   // Data taken on falling edge
	wire logic [15:0]  frame;       // Completed frame

	assign sclk_fall = sclk_q & ~cfg_sclk;
	assign frame     = {shreg, cfg_sdata};

	// Edge detect on the serial clock
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			sclk_q <= 1'b0;
		else
			sclk_q <= cfg_sclk;
	end

	// Shift while enabled; extra bits after a frame are ignored
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state   <= appc_pkg::SER_IDLE;
			shreg   <= '0;
			cnt     <= '0;
			wr_stb  <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
		end else begin
			wr_stb <= 1'b0;
			if (cfg_sen_b) begin
				state <= appc_pkg::SER_IDLE;
				cnt   <= '0;
			end else if (sclk_fall && state != appc_pkg::SER_HOLD) begin
				shreg <= frame[14:0];
				cnt   <= cnt + 5'h01;
				state <= appc_pkg::SER_SHIFT;
				if (cnt == appc_pkg::SER_LAST) begin
					// Full word: hand the write over
					state   <= appc_pkg::SER_HOLD;
					wr_stb  <= 1'b1;
					wr_addr <= frame[15:8];
					wr_data <= frame[7:0];
				end
			end
		end
	end

endmodule

// ==== verilog/appc_fir.sv ====
// Decimating FIR for one channel, 24 or 23 taps
`timescale 1ns/10ps
module appc_fir (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_b,
	input  wire logic                  in_valid,
	input  wire logic signed [11:0]    in_smp,
	input  wire logic                  filt_en,
	input  wire logic                  use_user,
	input  wire logic                  odd_taps,
	input  wire logic [2:0]            rate,
	input  wire logic [1:0]            band,
	input  wire logic [287:0]          usr_coef,
	output logic                       out_valid,
	output logic signed [11:0]         out_smp
);

	logic signed [11:0]                taps [appc_pkg::TAPS_ODD]; // History
	logic [2:0]                        phase;    // Decimation phase
	logic signed [appc_pkg::ACC_W-1:0] acc;      // Tap sum
	wire logic [2:0]                   last_ph;  // Factor minus one
	wire logic                         dec_last; // Keep this output

	// Factor: 2, 4, 8, else no decimation
	assign last_ph  = (rate == appc_pkg::RATE_DIV2) ? 3'h1 :
	                  (rate == appc_pkg::RATE_DIV4) ? 3'h3 :
	                  (rate == appc_pkg::RATE_DIV8) ? 3'h7 : 3'h0;
	assign dec_last = (phase == last_ph);

	// Multiply-accumulate over all taps; odd mode zeroes the last tap
	always_comb begin
		logic signed [11:0] s;
		logic signed [11:0] c;
		s   = '0;
		c   = '0;
		acc = '0;
		for (int i = 0; i < appc_pkg::TAPS_EVEN; i++) begin
			s = (i == 0) ? in_smp : taps[i-1];
			c = use_user ? usr_coef[i*appc_pkg::COEF_W +: appc_pkg::COEF_W]
			             : appc_pkg::builtin_coef(rate, band, 5'(i));
			if (odd_taps && i == appc_pkg::TAPS_ODD)
				c = '0;
			acc = acc + appc_pkg::ACC_W'(s * c);
		end
	end

	// History, phase and registered output
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < appc_pkg::TAPS_ODD; i++)
				taps[i] <= '0;
			phase     <= '0;
			out_valid <= 1'b0;
			out_smp   <= '0;
		end else begin
			out_valid <= in_valid & (~filt_en | dec_last);
			if (in_valid) begin
				taps[0] <= in_smp;
				for (int i = 1; i < appc_pkg::TAPS_ODD; i++)
					taps[i] <= taps[i-1];
				phase   <= (~filt_en | dec_last) ? 3'h0 : phase + 3'h1;
				out_smp <= filt_en ?
				           appc_pkg::sat_smp(acc >>> appc_pkg::SUM_SHIFT) :
				           in_smp;
			end
		end
	end

endmodule

// ==== verilog/appc_top.sv ====
// Post-processing path for a dual-channel 12-bit converter core
`timescale 1ns/10ps

// Overview of operation
// - Time-constant code sets averaging period exponent
// - Normal path delivers samples after 14 clocks
// - Fast path bypasses processing, 10 clock delay
// - Rate 000 decimates by two
// - Rate 001 decimates by four
// - Rate 011 no decimation, user coefficients only
// - Rate 100 decimates by eight, user only
// - Parity bit picks 24 or 23 taps
// - Filter-active bit routes samples through filter
// - Source bit picks built-in or user coefficients
// - Enable bit switches automatic offset correction
// - By two: band 00 low, 01 high
// - By four: low, band-pass 3Fs/16, 5Fs/16
// - By four: band 11 high-pass at 3Fs/8
module appc_top #(
	parameter int unsigned DC_TC_SIM_SHIFT = 0
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rst_b,
	input  wire logic                 cfg_sclk,
	input  wire logic                 cfg_sdata,
	input  wire logic                 cfg_sen_b,
	input  wire logic                 smp_valid,
	input  wire logic signed [11:0]   smp_a,
	input  wire logic signed [11:0]   smp_b,
	input  wire logic [287:0]         usr_coef,
	output logic                      out_valid,
	output logic signed [11:0]        out_a,
	output logic signed [11:0]        out_b,
	output logic signed [11:0]        dc_est_a,
	output logic signed [11:0]        dc_est_b
);

	// Configuration registers
	logic [7:0]  latency_and_dc_time;     // Fast path and time constant
	logic [7:0]  decimation_filter_ctrl;  // Offset, filter and rate
	logic [7:0]  filter_band_select;      // Band choice

	// Serial write port
	wire logic        wr_stb;   // One-cycle write
	wire logic [7:0]  wr_addr;  // Target address
	wire logic [7:0]  wr_data;  // Value written

	// Decoded fields
	wire logic        fast_path;          // Whole path bypassed
	wire logic [2:0]  dc_removal_time_constant; // Averaging code
	wire logic        dc_en;              // Offset correction on
	wire logic        coef_src;           // User coefficients chosen
	wire logic        filt_en;            // Filter in the path
	wire logic        odd_taps;           // 23-tap mode
	wire logic [2:0]  rate;               // Decimation code
	wire logic [1:0]  band;               // Band code
	wire logic        use_user;           // Effective coefficient source

	// Offset correction state
	logic [appc_pkg::DC_CNT_W-1:0]     dc_cnt;       // Samples in period
	logic signed [appc_pkg::DC_ACC_W-1:0] dc_acc [2]; // Running sums
	logic signed [11:0]                dc_off [2];   // Current estimates
	wire logic [4:0]                   dc_exp;       // Effective exponent
	wire logic [appc_pkg::DC_CNT_W-1:0] dc_last_cnt; // Period minus one
	wire logic                         dc_last;      // Period ends now
	wire logic signed [appc_pkg::DC_ACC_W-1:0] dc_sum [2]; // Sum with new

	// Front stages
	logic signed [11:0]  raw_q [2];   // Stage one samples
	logic                raw_v;       // Stage one valid
	logic signed [11:0]  cor_q [2];   // Stage two, offset removed
	logic                cor_v;       // Stage two valid
	wire logic signed [11:0] cor_next [2]; // Corrected value
	wire logic signed [11:0] fir_q [2];    // Stage three samples
	wire logic               fir_v [2];    // Stage three valid

	// Delay pads that bring both routes to their fixed latency
	logic signed [11:0]  norm_a [appc_pkg::NORM_PAD];
	logic signed [11:0]  norm_b [appc_pkg::NORM_PAD];
	logic                norm_v [appc_pkg::NORM_PAD];
	logic signed [11:0]  fast_a [appc_pkg::FAST_PAD];
	logic signed [11:0]  fast_b [appc_pkg::FAST_PAD];
	logic                fast_v [appc_pkg::FAST_PAD];

	// Register write decode
	wire logic wr_lat  = wr_stb && wr_addr == appc_pkg::ADDR_LAT_DC;
	wire logic wr_dec  = wr_stb && wr_addr == appc_pkg::ADDR_DEC_CTRL;
	wire logic wr_band = wr_stb && wr_addr == appc_pkg::ADDR_BAND;

	// Serial configuration port
	appc_cfg_rx u_cfg (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.cfg_sclk  (cfg_sclk),
		.cfg_sdata (cfg_sdata),
		.cfg_sen_b (cfg_sen_b),
		.wr_stb    (wr_stb),
		.wr_addr   (wr_addr),
		.wr_data   (wr_data)
	);

	// Register file; fixed-zero bits are stored as written
	// host keeps zeros
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			latency_and_dc_time    <= appc_pkg::RST_LAT_DC;
			decimation_filter_ctrl <= appc_pkg::RST_DEC_CTRL;
			filter_band_select     <= appc_pkg::RST_BAND;
		end else begin
			if (wr_lat)
				latency_and_dc_time <= wr_data;
			if (wr_dec)
				decimation_filter_ctrl <= wr_data;
			if (wr_band)
				filter_band_select <= wr_data;
		end
	end

	// Field extraction
	assign fast_path = latency_and_dc_time[appc_pkg::FAST_BIT];
	assign dc_removal_time_constant =
		latency_and_dc_time[appc_pkg::TC_LSB +: 3];
	assign dc_en    = decimation_filter_ctrl[appc_pkg::DC_EN_BIT];
	assign coef_src = decimation_filter_ctrl[appc_pkg::COEF_SRC_BIT];
	assign filt_en  = decimation_filter_ctrl[appc_pkg::FILT_EN_BIT];
	assign odd_taps = decimation_filter_ctrl[appc_pkg::ODD_TAP_BIT];
	assign rate     = decimation_filter_ctrl[appc_pkg::RATE_LSB +: 3];
	assign band     = filter_band_select[appc_pkg::BAND_LSB +: 2];

	assign use_user = coef_src || rate == appc_pkg::RATE_NONE ||
	                  rate == appc_pkg::RATE_DIV8;

	// period from time-constant code
	// Simulation may shrink the exponent; hardware uses zero
	assign dc_exp = appc_pkg::tc_exponent(dc_removal_time_constant) -
	                5'(DC_TC_SIM_SHIFT);
	assign dc_last_cnt = (appc_pkg::DC_CNT_W'(1) << dc_exp) -
	                     appc_pkg::DC_CNT_W'(1);
	assign dc_last = raw_v && dc_cnt == dc_last_cnt;
	assign dc_sum[0] = dc_acc[0] + appc_pkg::DC_ACC_W'(raw_q[0]);
	assign dc_sum[1] = dc_acc[1] + appc_pkg::DC_ACC_W'(raw_q[1]);

	assign cor_next[0] = dc_en ? appc_pkg::sat_smp(
		appc_pkg::ACC_W'(raw_q[0]) - appc_pkg::ACC_W'(dc_off[0])) : raw_q[0];
	assign cor_next[1] = dc_en ? appc_pkg::sat_smp(
		appc_pkg::ACC_W'(raw_q[1]) - appc_pkg::ACC_W'(dc_off[1])) : raw_q[1];

	// Estimates exposed for monitoring
	assign dc_est_a = dc_off[0];
	assign dc_est_b = dc_off[1];

	// Stage one: capture the converter samples
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			raw_q[0] <= '0;
			raw_q[1] <= '0;
			raw_v    <= 1'b0;
		end else begin
			raw_q[0] <= smp_a;
			raw_q[1] <= smp_b;
			raw_v    <= smp_valid;
		end
	end

	// Averaging over 2^N samples; a new estimate each period
	// Sums restart when correction is off, so a fresh enable
	// starts from a clean window rather than a stale one
	// averaging window
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dc_cnt <= '0;
			for (int c = 0; c < 2; c++) begin
				dc_acc[c] <= '0;
				dc_off[c] <= '0;
			end
		end else if (!dc_en) begin
			dc_cnt <= '0;
			for (int c = 0; c < 2; c++) begin
				dc_acc[c] <= '0;
				dc_off[c] <= '0;
			end
		end else if (raw_v) begin
			dc_cnt <= dc_last ? '0 : dc_cnt + appc_pkg::DC_CNT_W'(1);
			for (int c = 0; c < 2; c++) begin
				dc_acc[c] <= dc_last ? '0 : dc_sum[c];
				if (dc_last)
					dc_off[c] <= 12'(dc_sum[c] >>> dc_exp);
			end
		end
	end

	// Stage two: offset removed
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cor_q[0] <= '0;
			cor_q[1] <= '0;
			cor_v    <= 1'b0;
		end else begin
			cor_q[0] <= cor_next[0];
			cor_q[1] <= cor_next[1];
			cor_v    <= raw_v;
		end
	end

	// Stage three: one filter per channel, same settings for both
	// filter and decimation
	for (genvar c = 0; c < 2; c++) begin : g_fir
		appc_fir u_fir (
			.sys_clk   (sys_clk),
			.rst_b     (rst_b),
			.in_valid  (cor_v),
			.in_smp    (cor_q[c]),
			.filt_en   (filt_en),
			.use_user  (use_user),
			.odd_taps  (odd_taps),
			.rate      (rate),
			.band      (band),
			.usr_coef  (usr_coef),
			.out_valid (fir_v[c]),
			.out_smp   (fir_q[c])
		);
	end

	// Normal-route pad after the filter
	// pad to fourteen clocks
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < appc_pkg::NORM_PAD; i++) begin
				norm_a[i] <= '0;
				norm_b[i] <= '0;
				norm_v[i] <= 1'b0;
			end
		end else begin
			norm_a[0] <= fir_q[0];
			norm_b[0] <= fir_q[1];
			norm_v[0] <= fir_v[0] & fir_v[1];
			for (int i = 1; i < appc_pkg::NORM_PAD; i++) begin
				norm_a[i] <= norm_a[i-1];
				norm_b[i] <= norm_b[i-1];
				norm_v[i] <= norm_v[i-1];
			end
		end
	end

	// Fast-route pad straight from stage one
	// pad to ten clocks
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < appc_pkg::FAST_PAD; i++) begin
				fast_a[i] <= '0;
				fast_b[i] <= '0;
				fast_v[i] <= 1'b0;
			end
		end else begin
			fast_a[0] <= raw_q[0];
			fast_b[0] <= raw_q[1];
			fast_v[0] <= raw_v;
			for (int i = 1; i < appc_pkg::FAST_PAD; i++) begin
				fast_a[i] <= fast_a[i-1];
				fast_b[i] <= fast_b[i-1];
				fast_v[i] <= fast_v[i-1];
			end
		end
	end

	// Output register picks the route; both keep running, so
	// settings survive a fast-path spell untouched. A switch
	// mid-stream may repeat or drop a few samples.
	// settings kept, ignored
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_a     <= '0;
			out_b     <= '0;
			out_valid <= 1'b0;
		end else if (fast_path) begin
			out_a     <= fast_a[appc_pkg::FAST_PAD-1];
			out_b     <= fast_b[appc_pkg::FAST_PAD-1];
			out_valid <= fast_v[appc_pkg::FAST_PAD-1];
		end else begin
			out_a     <= norm_a[appc_pkg::NORM_PAD-1];
			out_b     <= norm_b[appc_pkg::NORM_PAD-1];
			out_valid <= norm_v[appc_pkg::NORM_PAD-1];
		end
	end

endmodule

// ==== tb/appc_top_sva.sv ====
// Port-level checker of the sample post-processing block
`timescale 1ns/10ps
module appc_top_sva (
	input wire logic               sys_clk,
	input wire logic               rst_b,
	input wire logic               cfg_sclk,
	input wire logic               cfg_sdata,
	input wire logic               cfg_sen_b,
	input wire logic               smp_valid,
	input wire logic signed [11:0] smp_a,
	input wire logic signed [11:0] smp_b,
	input wire logic               out_valid,
	input wire logic signed [11:0] out_a,
	input wire logic signed [11:0] out_b,
	input wire logic signed [11:0] dc_est_a,
	input wire logic signed [11:0] dc_est_b
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic        sclk_q; // Serial clock one cycle ago
	logic [4:0]  nbit;   // Bits taken in this frame
	logic [14:0] sh;     // Frame bits so far
	logic [7:0]  lat;    // Shadow of the latency register
	logic [7:0]  dec;    // Shadow of the decimation control
	wire         take = !cfg_sen_b && sclk_q && !cfg_sclk && nbit < 5'h10;
	wire [15:0]  word = {sh, cfg_sdata};
	wire         last = take && nbit == 5'h0f;
	wire         fast = lat[7];
	wire         filt = dec[4] && !fast;
	wire [2:0]   rate = dec[2:0];
	// Shadows follow serial writes; leads the design by one edge,
	// harmless since the bench drains samples around writes
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_q <= 1'b0;
			nbit   <= 5'h00;
			sh     <= 15'h0000;
			lat    <= 8'h00;
			dec    <= 8'h00;
		end else begin
			sclk_q <= cfg_sclk;
			nbit   <= cfg_sen_b ? 5'h00 : nbit + 5'(take);
			if (take)
				sh <= word[14:0];
			if (last && word[15:8] == appc_pkg::ADDR_LAT_DC)
				lat <= word[7:0];
			if (last && word[15:8] == appc_pkg::ADDR_DEC_CTRL)
				dec <= word[7:0];
		end
	end
	fast_lat_a: assert property (fast |-> out_valid == $past(smp_valid, 10))
		else $error("fast path latency wrong");
	fast_data_a: assert property (fast && out_valid |->
		out_a == $past(smp_a, 10) && out_b == $past(smp_b, 10))
		else $error("fast path sample altered");
	norm_lat_a: assert property (!fast && !dec[4] |->
		out_valid == $past(smp_valid, 14))
		else $error("normal path latency wrong");
	thru_data_a: assert property (!fast && !dec[4] && !dec[7] && out_valid
		|-> out_a == $past(smp_a, 14) && out_b == $past(smp_b, 14))
		else $error("bypassed filter altered sample");
	dc_off_a: assert property (!dec[7] [*4] |->
		dc_est_a == 12'sh000 && dc_est_b == 12'sh000)
		else $error("offset estimate kept while disabled");
	div2_gap_a: assert property (filt && rate == 3'h0 && out_valid |=> !out_valid)
		else $error("decimate by two too dense");
	div4_gap_a: assert property (filt && rate == 3'h1 && out_valid |=> !out_valid [*3])
		else $error("decimate by four too dense");
	div8_gap_a: assert property (filt && rate == 3'h4 && out_valid |=> !out_valid [*7])
		else $error("decimate by eight too dense");
	nodec_lat_a: assert property (filt && rate == 3'h3 |->
		out_valid == $past(smp_valid, 14))
		else $error("undecimated filter drops samples");
	cover property (fast && out_valid);
	cover property (filt && rate == 3'h4 && out_valid);
	cover property (dec[7] && dc_est_a != 12'sh000);
endmodule

bind appc_top appc_top_sva chk (.sys_clk(sys_clk), .rst_b(rst_b),
	.cfg_sclk(cfg_sclk), .cfg_sdata(cfg_sdata), .cfg_sen_b(cfg_sen_b),
	.smp_valid(smp_valid), .smp_a(smp_a), .smp_b(smp_b),
	.out_valid(out_valid), .out_a(out_a), .out_b(out_b),
	.dc_est_a(dc_est_a), .dc_est_b(dc_est_b));

// ==== tb/appc_host_model.sv ====
// Host model writing settings over the serial configuration port
`timescale 1ns/10ps
module appc_host_model (
	input  wire logic sys_clk,
	output logic      cfg_sclk,
	output logic      cfg_sdata,
	output logic      cfg_sen_b
);
	int unsigned hold = 1; // Cycles per serial clock phase, sets speed
	// Released lines rest at their pull levels
	initial begin
		cfg_sclk  = 1'b0;
		cfg_sdata = 1'b0;
		cfg_sen_b = 1'b1;
	end
	// One 16-bit frame, address then data, MSB first
	task automatic write(input logic [7:0] addr, input logic [7:0] data);
		logic [7:0] d;
		d = data;
		if (addr == appc_pkg::ADDR_BAND)
			d = data & 8'h03;
		if (addr == appc_pkg::ADDR_DEC_CTRL)
			d = data & 8'hbf;
		@(negedge sys_clk);
		cfg_sen_b = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			cfg_sclk  = 1'b1;
			cfg_sdata = i > 7 ? addr[i-8] : d[i];
			repeat (hold) @(negedge sys_clk);
			cfg_sclk = 1'b0;
			repeat (hold) @(negedge sys_clk);
		end
		cfg_sen_b = 1'b1;
		cfg_sdata = 1'b0;
		// Room for the register update to land
		repeat (4) @(negedge sys_clk);
	endtask
endmodule

// ==== tb/tb_adc_post_processing_ctrl.sv ====
// Self-checking bench of the sample post-processing block
`timescale 1ns/10ps
module tb_adc_post_processing_ctrl;
	typedef struct {
		logic               chk; // Values known in advance
		logic signed [11:0] a;
		logic signed [11:0] b;
		int                 t;   // Cycle the result is due
	} appc_exp_t;
	logic               sys_clk;
	logic               rst_b;
	wire logic          cfg_sclk;
	wire logic          cfg_sdata;
	wire logic          cfg_sen_b;
	logic               smp_valid;
	logic signed [11:0] smp_a;
	logic signed [11:0] smp_b;
	logic [287:0]       usr_coef;
	logic               out_valid;
	logic signed [11:0] out_a;
	logic signed [11:0] out_b;
	logic signed [11:0] dc_est_a;
	logic signed [11:0] dc_est_b;
	int                 cyc = 0;        // Rising edges so far
	int                 n_mismatch = 0;
	int                 n_compared = 0;
	appc_exp_t          expq[$];        // Results still due
	logic signed [11:0] ha[$];          // Filter history, newest first
	logic signed [11:0] hb[$];
	// Averaging exponents per time-constant code
	int exps[8] = '{27, 26, 25, 24, 28, 29, 27, 27};
	// Band in [9:8], decimation control in [7:0]
	logic [9:0] cfgs[11] = '{10'h030, 10'h110, 10'h210, 10'h011, 10'h111,
		10'h211, 10'h311, 10'h03b, 10'h013, 10'h034, 10'h01c};
	appc_top #(.DC_TC_SIM_SHIFT(20)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.cfg_sclk(cfg_sclk), .cfg_sdata(cfg_sdata), .cfg_sen_b(cfg_sen_b),
		.smp_valid(smp_valid), .smp_a(smp_a), .smp_b(smp_b),
		.usr_coef(usr_coef), .out_valid(out_valid), .out_a(out_a),
		.out_b(out_b), .dc_est_a(dc_est_a), .dc_est_b(dc_est_b));
	appc_host_model host (.sys_clk(sys_clk), .cfg_sclk(cfg_sclk),
		.cfg_sdata(cfg_sdata), .cfg_sen_b(cfg_sen_b));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cyc <= cyc + 1;
	task automatic check(input string what, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// One sample per call, driven off the sampling edge
	task automatic feed(input logic signed [11:0] a, b);
		@(negedge sys_clk);
		smp_valid = 1'b1;
		smp_a     = a;
		smp_b     = b;
	endtask
	task automatic due(input logic c, input logic signed [11:0] a, b,
		input int lat);
		expq.push_back('{c, a, b, cyc + lat});
	endtask
	// Idle samples carry changing junk so stale data cannot pass
	task automatic idle(input int n);
		@(negedge sys_clk);
		smp_valid = 1'b0;
		smp_a     = ~smp_a;
		smp_b     = ~smp_b;
		repeat (n) @(negedge sys_clk);
	endtask
	function automatic logic signed [11:0] coef(input logic [7:0] c,
		input logic [1:0] band, input int i);
		logic [3:0] k;
		logic       neg;
		k = 4'(i);
		neg = band == 2'h1 ? appc_pkg::BP3_NEG[k] :
			band == 2'h2 ? appc_pkg::BP5_NEG[k] : band == 2'h3 && k[0];
		if (c[3] && i == 23)
			return 12'sh000;
		if (c[5] || c[2:0] == 3'h3 || c[2:0] == 3'h4)
			return usr_coef[12*i +: 12];
		if (c[2:0] == 3'h0)
			neg = band[0] && k[0];
		if (c[2:0] == 3'h0 && band[1])
			return 12'sh000;
		return neg ? -appc_pkg::BI_MAG : appc_pkg::BI_MAG;
	endfunction
	function automatic logic signed [11:0] fir(input logic signed [11:0] h[$],
		input logic [7:0] c, input logic [1:0] band);
		int s;
		s = 0;
		for (int i = 0; i < h.size(); i++)
			s = s + int'(h[i]) * int'(coef(c, band, i));
		s = s >>> 9;
		return s > 2047 ? 12'sh7ff : s < -2048 ? 12'sh800 : 12'(s);
	endfunction
	// Results are compared in order as they appear
	always @(negedge sys_clk) begin
		appc_exp_t e;
		if (out_valid === 1'b1 && expq.size() == 0)
			check("unexpected output", 1, 0);
		else if (out_valid === 1'b1) begin
			e = expq.pop_front();
			check("latency", cyc, e.t);
			if (e.chk) begin
				check("out a", out_a, e.a);
				check("out b", out_b, e.b);
			end
		end
	end
	initial begin
		repeat (30000) @(posedge sys_clk);
		n_mismatch++;
		test_done;
	end
	initial begin
		logic signed [11:0] ra;
		logic signed [11:0] rb;
		logic [7:0]         c;
		logic [1:0]         band;
		int                 n;
		int                 p;
		void'($urandom(9050));
		rst_b = 1'b0;
		smp_valid = 1'b0;
		smp_a = 12'sh000;
		smp_b = 12'sh000;
		usr_coef = '0;
		repeat (4) @(negedge sys_clk);
		rst_b = 1'b1;
		check("reset out", {out_valid, out_a, dc_est_a}, 25'h0);
		// Plain path, random gaps
		for (int i = 0; i < 40; i++) begin
			ra = 12'($urandom);
			rb = 12'($urandom);
			if ($urandom_range(3) != 0) begin
				feed(ra, rb);
				due(1'b1, ra, rb, 14);
			end else
				idle(0);
		end
		idle(20);
		$display("test pass-through done");
		// Fast path must ignore filter and offset settings
		host.write(appc_pkg::ADDR_DEC_CTRL, 8'h91);
		host.write(appc_pkg::ADDR_LAT_DC, 8'h80);
		for (int i = 0; i < 20; i++) begin
			ra = 12'($urandom);
			rb = 12'($urandom);
			feed(ra, rb);
			due(1'b1, ra, rb, 10);
		end
		idle(20);
		host.write(appc_pkg::ADDR_LAT_DC, 8'h00);
		$display("test fast path done");
		// Every rate, parity, source and band
		for (int k = 0; k < 11; k++) begin
			c = cfgs[k][7:0];
			band = cfgs[k][9:8];
			n = c[2:0] == 3'h0 ? 2 : c[2:0] == 3'h1 ? 4 : c[2:0] == 3'h4 ? 8 : 1;
			host.hold = 1 + k % 3;
			for (int j = 0; j < 24; j++)
				usr_coef[12*j +: 12] = 12'($urandom_range(63)) - 12'h020;
			host.write(appc_pkg::ADDR_DEC_CTRL, 8'h00);
			host.write(appc_pkg::ADDR_BAND, {6'h00, band});
			host.write(appc_pkg::ADDR_DEC_CTRL, c);
			ha = {};
			hb = {};
			for (int i = 0; i < 72; i++) begin
				ra = i < 24 ? 12'sh000 : 12'($urandom);
				rb = i < 24 ? 12'sh000 : 12'($urandom);
				ha.push_front(ra);
				hb.push_front(rb);
				if (ha.size() > 24) begin
					void'(ha.pop_back());
					void'(hb.pop_back());
				end
				feed(ra, rb);
				if (i % n == n - 1)
					due(i >= 24, fir(ha, c, band), fir(hb, c, band), 14);
			end
			idle(20);
		end
		$display("test filter done");
		// Offset averaging period for every time-constant code
		for (int code = 0; code < 8; code++) begin
			p = 1 << (exps[code] - 20);
			ra = 12'($urandom_range(900)) + 12'sh001;
			rb = -ra;
			host.write(appc_pkg::ADDR_DEC_CTRL, 8'h00);
			host.write(appc_pkg::ADDR_LAT_DC, {1'b0, 3'(code), 4'h0});
			host.write(appc_pkg::ADDR_DEC_CTRL, 8'h80);
			for (int i = 0; i < 2 * p + 8; i++) begin
				feed(ra, rb);
				due(1'b0, ra, rb, 14);
				if (i == p / 2)
					check("early estimate", dc_est_a == ra, 1'b0);
			end
			check("estimate a", dc_est_a, ra);
			check("estimate b", dc_est_b, rb);
			for (int i = 0; i < 4; i++) begin
				feed(ra, rb);
				due(1'b1, 12'sh000, 12'sh000, 14);
			end
			idle(20);
		end
		host.write(appc_pkg::ADDR_DEC_CTRL, 8'h00);
		idle(4);
		check("estimate off", dc_est_a, 12'sh000);
		$display("test offset done");
		check("results left", expq.size(), 0);
		test_done;
	end
endmodule
